// [src/gpiode_top.sv]
// Purpose: pad logic with input, output and drive-enable registers, dual-edge
// Assumes: capture and launch clocks far slower than mclk, oversampled here
// Notes:   registered samples reach the core through a 17-word buffer
`timescale 1ns/1ps
`default_nettype none

`include "gpiode_regs.svh"

// Functional notes
// - without dual-edge, the pad value appears on sample bit 0
// - dual-edge input: rising sample on bit 0, falling sample on bit 1
// - dual-edge words are two bits wide, sampled on both edges
// - without dual-edge, the pad is driven from drive bit 0
// - drive enable from core, registered or passed straight
// - only launch clock edges update output and drive-enable registers
// - only capture clock edges update the input sampling registers
// - secondary route works only with input registering off
// - normal dual-edge moves data on both rising and falling edges
// - resync dual-edge hands both bits over on rising edge only
// - resync holds falling sample half a period until next rise
// - pad is input, output, bidir, clock out or unused
// - registered output may be inverted onto the pad
// - each register chooses rising or falling edge of its clock; input and output registers only without dual-edge
// - during configuration the pad floats with weak pull-up
module gpiode_top (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       pad_in,
  output logic            pad_out,
  output logic            pad_oe,
  output logic            pad_pull_up,
  input  wire logic       launch_clock,
  input  wire logic       capture_clock,
  input  wire logic       configuring,
  input  wire logic [4:0] pad_mode,
  input  wire logic [2:0] dual_edge_io,
  input  wire logic       in_reg_en,
  input  wire logic       in_edge_fall,
  input  wire logic       out_reg_en,
  input  wire logic       out_invert,
  input  wire logic       out_edge_fall,
  input  wire logic       oe_reg_en,
  input  wire logic       oe_edge_fall,
  input  wire logic [1:0] drive_data,
  input  wire logic       drive_en,
  output logic      [1:0] sample_data,
  output logic            sample_valid,
  input  wire logic       sample_ready,
  output logic      [1:0] pad_direct,
  input  wire logic [4:0] secondary_dest,
  output logic      [4:0] secondary_pad_route,
  output logic            overrun,
  input  wire logic       overrun_clear
);

  function automatic logic settle(input logic s2, input logic s3,
                                  input logic old);
    settle = (s2 == s3) ? s3 : old;
  endfunction : settle

  function automatic logic rose(input logic prev, input logic cur);
    rose = ~prev & cur;
  endfunction : rose

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction : fell

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] filt;
  logic [2:0] filt_prev;
  logic       pad_f;
  logic       cap_r;
  logic       cap_f;
  logic       lch_r;
  logic       lch_f;

  logic       m_unused;
  logic       m_input;
  logic       m_output;
  logic       m_bidir;
  logic       m_clkout;
  logic       de_none;
  logic       de_normal;
  logic       de_resync;
  logic       in_act;

  logic       rise_q;
  logic       fall_q;
  logic       next_rise_q;
  logic       next_fall_q;
  logic [1:0] next_word;
  logic       next_push;
  logic       fifo_ready;

  logic       out_val;
  logic       out_hold1;
  logic       oe_val;

  // inputs from outside mclk: three flops, accepted once stages 2 and 3 agree
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sync1 <= `GPIODE_RST_SYNC;
      sync2 <= `GPIODE_RST_SYNC;
      sync3 <= `GPIODE_RST_SYNC;
    end
    else
    begin
      sync1 <= {launch_clock, capture_clock, pad_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      filt      <= `GPIODE_RST_SYNC;
      filt_prev <= `GPIODE_RST_SYNC;
    end
    else
    begin
      for (int i = 0; i < `GPIODE_SYNC_STAGES; i++)
      begin
        filt[i] <= settle(sync2[i], sync3[i], filt[i]);
      end
      filt_prev <= filt;
    end
  end

  assign pad_f = filt[`GPIODE_PAD_BIT];
  assign cap_r = rose(filt_prev[`GPIODE_CAP_BIT], filt[`GPIODE_CAP_BIT]);
  assign cap_f = fell(filt_prev[`GPIODE_CAP_BIT], filt[`GPIODE_CAP_BIT]);
  assign lch_r = rose(filt_prev[`GPIODE_LAUNCH_BIT], filt[`GPIODE_LAUNCH_BIT]);
  assign lch_f = fell(filt_prev[`GPIODE_LAUNCH_BIT], filt[`GPIODE_LAUNCH_BIT]);

  always_comb
  begin
    m_unused = 1'b0;
    m_input  = 1'b0;
    m_output = 1'b0;
    m_bidir  = 1'b0;
    m_clkout = 1'b0;
    unique case (gpiode_pkg::gpiode_mode_t'(pad_mode))
      gpiode_pkg::GPIODE_MODE_UNUSED: m_unused = 1'b1;
      gpiode_pkg::GPIODE_MODE_INPUT:  m_input  = 1'b1;
      gpiode_pkg::GPIODE_MODE_OUTPUT: m_output = 1'b1;
      gpiode_pkg::GPIODE_MODE_BIDIR:  m_bidir  = 1'b1;
      gpiode_pkg::GPIODE_MODE_CLKOUT: m_clkout = 1'b1;
      default:                        m_unused = 1'b1;
    endcase
  end

  always_comb
  begin
    de_none   = 1'b0;
    de_normal = 1'b0;
    de_resync = 1'b0;
    unique case (gpiode_pkg::gpiode_de_t'(dual_edge_io))
      gpiode_pkg::GPIODE_DE_NONE:   de_none   = 1'b1;
      gpiode_pkg::GPIODE_DE_NORMAL: de_normal = 1'b1;
      gpiode_pkg::GPIODE_DE_RESYNC: de_resync = 1'b1;
      default:                      de_none   = 1'b1;
    endcase
  end

  // input path keeps running in bidir whatever the drive enable says
  assign in_act = (m_input | m_bidir) & ~configuring;

  // capture word building; state advances only while the buffer has room
  always_comb
  begin
    next_rise_q = rise_q;
    next_fall_q = fall_q;
    next_word   = `GPIODE_RST_WORD;
    next_push   = 1'b0;
    if (in_act & in_reg_en)
    begin
      if (de_none)
      begin
        if (in_edge_fall ? cap_f : cap_r)
        begin
          next_word[`GPIODE_RISE_BIT] = pad_f;
          next_push = 1'b1;
        end
      end
      else if (de_normal)
      begin
        if (cap_r)
        begin
          next_word   = {fall_q, pad_f};
          next_rise_q = pad_f;
          next_push   = 1'b1;
        end
        if (cap_f)
        begin
          next_word   = {pad_f, rise_q};
          next_fall_q = pad_f;
          next_push   = 1'b1;
        end
      end
      else if (de_resync)
      begin
        if (cap_r)
        begin
          next_word   = {fall_q, rise_q};
          next_rise_q = pad_f;
          next_push   = 1'b1;
        end
        if (cap_f)
        begin
          next_fall_q = pad_f;
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else if (fifo_ready)
    begin
      rise_q <= next_rise_q;
      fall_q <= next_fall_q;
    end
  end

  // a sample lost to a full buffer sets overrun; set wins over clear
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      overrun <= 1'b0;
    end
    else if (next_push & ~fifo_ready)
    begin
      overrun <= 1'b1;
    end
    else if (overrun_clear)
    begin
      overrun <= 1'b0;
    end
  end

  gpiode_fifo #(
    .WIDTH (`GPIODE_FIFO_WIDTH),
    .DEPTH (`GPIODE_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_data   (next_word),
    .in_valid  (next_push),
    .in_ready  (fifo_ready),
    .out_data  (sample_data),
    .out_valid (sample_valid),
    .out_ready (sample_ready)
  );

  // unregistered input and the secondary route
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pad_direct          <= `GPIODE_RST_WORD;
      secondary_pad_route <= `GPIODE_RST_ROUTE;
    end
    else
    begin
      pad_direct <= {1'b0, pad_f & in_act & ~in_reg_en};
      if (m_input & ~in_reg_en & ~configuring)
      begin
        secondary_pad_route <= secondary_dest & {5{pad_f}};
      end
      else
      begin
        secondary_pad_route <= `GPIODE_RST_ROUTE;
      end
    end
  end

  // output data register, stepped by launch clock edges only
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      out_val   <= `GPIODE_RST_PAD_OUT;
      out_hold1 <= `GPIODE_RST_PAD_OUT;
    end
    else if (!out_reg_en)
    begin
      out_val <= drive_data[`GPIODE_RISE_BIT];
    end
    else if (de_none)
    begin
      if (out_edge_fall ? lch_f : lch_r)
      begin
        out_val <= drive_data[`GPIODE_RISE_BIT];
      end
    end
    else if (de_normal)
    begin
      if (lch_r)
      begin
        out_val <= drive_data[`GPIODE_RISE_BIT];
      end
      else if (lch_f)
      begin
        out_val <= drive_data[`GPIODE_FALL_BIT];
      end
    end
    else if (de_resync)
    begin
      if (lch_r)
      begin
        out_val   <= drive_data[`GPIODE_RISE_BIT];
        out_hold1 <= drive_data[`GPIODE_FALL_BIT];
      end
      else if (lch_f)
      begin
        out_val <= out_hold1;
      end
    end
  end

  // drive-enable register, also on launch clock edges only
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      oe_val <= `GPIODE_RST_PAD_OE;
    end
    else if (!oe_reg_en)
    begin
      oe_val <= drive_en;
    end
    else if (oe_edge_fall ? lch_f : lch_r)
    begin
      oe_val <= drive_en;
    end
  end

  // pad drivers per mode
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pad_out     <= `GPIODE_RST_PAD_OUT;
      pad_oe      <= `GPIODE_RST_PAD_OE;
      pad_pull_up <= `GPIODE_RST_PULL_UP;
    end
    else if (configuring | m_unused)
    begin
      pad_out     <= `GPIODE_RST_PAD_OUT;
      pad_oe      <= 1'b0;
      pad_pull_up <= 1'b1;
    end
    else
    begin
      pad_pull_up <= 1'b0;
      if (m_clkout)
      begin
        pad_out <= filt[`GPIODE_LAUNCH_BIT];
      end
      else
      begin
        pad_out <= out_val ^ (out_reg_en & out_invert);
      end
      pad_oe <= m_output | m_clkout | (m_bidir & oe_val);
    end
  end

endmodule : gpiode_top

`default_nettype wire

// [src/gpiode_regs.svh]
// Purpose: timing counts, bit positions and reset values of the dual-edge pad
// Assumes: included by bare name from the top-level design file
// Notes:   definitions only
`ifndef GPIODE_REGS_SVH
`define GPIODE_REGS_SVH

`define GPIODE_CLK_PERIOD_NS   5
`define GPIODE_SYNC_STAGES     3
`define GPIODE_FIFO_WIDTH      2
`define GPIODE_FIFO_DEPTH      16
`define GPIODE_RISE_BIT        0
`define GPIODE_FALL_BIT        1
`define GPIODE_PAD_BIT         0
`define GPIODE_CAP_BIT         1
`define GPIODE_LAUNCH_BIT      2
`define GPIODE_RST_PAD_OUT     1'b0
`define GPIODE_RST_PAD_OE      1'b0
`define GPIODE_RST_PULL_UP     1'b1
`define GPIODE_RST_SYNC        3'h0
`define GPIODE_RST_WORD        2'h0
`define GPIODE_RST_ROUTE       5'h00

`endif

// [src/gpiode_pkg.sv]
// Purpose: types shared by the dual-edge pad logic
// Assumes: nothing
// Notes:   one-hot codes; other codes fall back to unused mode and no dual-edge
package gpiode_pkg;

  typedef enum logic [4:0] {
    GPIODE_MODE_UNUSED = 5'h01,
    GPIODE_MODE_INPUT  = 5'h02,
    GPIODE_MODE_OUTPUT = 5'h04,
    GPIODE_MODE_BIDIR  = 5'h08,
    GPIODE_MODE_CLKOUT = 5'h10
  } gpiode_mode_t;

  typedef enum logic [2:0] {
    GPIODE_DE_NONE   = 3'h1,
    GPIODE_DE_NORMAL = 3'h2,
    GPIODE_DE_RESYNC = 3'h4
  } gpiode_de_t;

endpackage : gpiode_pkg

// [src/gpiode_fifo.sv]
// Purpose: sample buffer between the capture logic and the core
// Assumes: single clock, synchronous active-low reset
// Notes:   registered output stage in front of the storage array
`timescale 1ns/1ps
`default_nettype none

module gpiode_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign do_wr    = in_valid & in_ready;
  assign do_rd    = (count != '0) & (~out_valid | out_ready);

  always_ff @(posedge mclk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (do_rd)
      begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= (AW+1)'(count + (AW+1)'(do_wr) - (AW+1)'(do_rd));
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end
    else if (do_rd)
    begin
      out_data  <= mem[rd_ptr];
      out_valid <= 1'b1;
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule : gpiode_fifo

`default_nettype wire

// [sim/gpiode_top_asserts.sv]
// Purpose: concurrent checks on the dual-edge pad ports
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to gpiode_top below
`timescale 1ns/1ps
`default_nettype none

module gpiode_chk (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       pad_out,
  input wire logic       pad_oe,
  input wire logic       pad_pull_up,
  input wire logic       configuring,
  input wire logic [4:0] pad_mode,
  input wire logic       in_reg_en,
  input wire logic       out_reg_en,
  input wire logic       oe_reg_en,
  input wire logic [1:0] drive_data,
  input wire logic       drive_en,
  input wire logic [1:0] sample_data,
  input wire logic       sample_valid,
  input wire logic       sample_ready,
  input wire logic [4:0] secondary_pad_route,
  input wire logic       overrun,
  input wire logic       overrun_clear
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_cfg_float:
    assert property (configuring [*2] |-> !pad_oe && pad_pull_up)
    else $error("pad driven during configuration");
  chk_unused_float:
    assert property ((pad_mode == gpiode_pkg::GPIODE_MODE_UNUSED) [*3]
      |-> !pad_oe && pad_pull_up) else $error("unused pad driven");
  chk_input_nodrive:
    assert property ((pad_mode == gpiode_pkg::GPIODE_MODE_INPUT) [*3]
      |-> !pad_oe) else $error("input pad driven");
  chk_output_drive:
    assert property ((pad_mode == gpiode_pkg::GPIODE_MODE_OUTPUT
      && !configuring) [*3] |-> pad_oe) else $error("output pad floats");
  chk_bidir_enable:
    assert property ((pad_mode == gpiode_pkg::GPIODE_MODE_BIDIR && !oe_reg_en
      && !configuring) [*3] |-> pad_oe == $past(drive_en, 2))
    else $error("direct drive enable not followed");
  chk_unreg_out:
    assert property ((pad_mode == gpiode_pkg::GPIODE_MODE_OUTPUT
      && !out_reg_en && !configuring) [*3]
      |-> pad_out == $past(drive_data[0], 2)) else $error("pad_out wrong");
  chk_route_gate:
    assert property ((in_reg_en || pad_mode != gpiode_pkg::GPIODE_MODE_INPUT)
      [*2] |-> secondary_pad_route == 5'h00) else $error("route not gated");
  chk_head_hold:
    assert property (sample_valid && !sample_ready
      |=> sample_valid && $stable(sample_data)) else $error("head moved");
  chk_overrun_sticky:
    assert property (overrun && !overrun_clear |=> overrun)
    else $error("overrun lost");
endmodule : gpiode_chk

bind gpiode_top gpiode_chk u_chk (
  .mclk(mclk), .rst_b(rst_b), .pad_out(pad_out), .pad_oe(pad_oe),
  .pad_pull_up(pad_pull_up), .configuring(configuring),
  .pad_mode(pad_mode), .in_reg_en(in_reg_en), .out_reg_en(out_reg_en),
  .oe_reg_en(oe_reg_en), .drive_data(drive_data), .drive_en(drive_en),
  .sample_data(sample_data), .sample_valid(sample_valid),
  .sample_ready(sample_ready), .secondary_pad_route(secondary_pad_route),
  .overrun(overrun), .overrun_clear(overrun_clear)
);

`default_nettype wire

// [sim/gpiode_pad_model.sv]
// Purpose: board side of the pad wire
// Assumes: device and board never drive together
// Notes:   a floating wire without pull-up shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none

module gpiode_pad_model (
  input  wire logic pad_out,
  input  wire logic pad_oe,
  input  wire logic pad_pull_up,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pad_wire
);
  logic last = 1'b0;

  always @*
    if (pad_oe)
      pad_wire = pad_out;
    else if (ext_en)
      pad_wire = ext_val;
    else if (pad_pull_up)
      pad_wire = 1'b1;
    else
      pad_wire = ~last;

  always @(pad_wire)
    if (pad_oe || ext_en)
      last = pad_wire;
endmodule : gpiode_pad_model

`default_nettype wire

// [sim/gpiode_top_tb.sv]
// Purpose: self-checking bench for the dual-edge pad logic
// Assumes: launch half periods of at least 11 mclk cycles, capture half periods of 16
// Notes:   board drives the pad through the pad model
`timescale 1ns/1ps
`default_nettype none

module gpiode_top_tb;
  logic       mclk, rst_b, pad_wire, pad_out, pad_oe, pad_pull_up;
  logic       launch_clock, capture_clock, configuring, drive_en;
  logic [4:0] pad_mode, secondary_dest, secondary_pad_route;
  logic [2:0] dual_edge_io, de;
  logic       in_reg_en, out_reg_en, out_invert, oe_reg_en, fall0;
  logic       sample_valid, sample_ready, overrun, overrun_clear;
  logic       ext_en, ext_val;
  logic [1:0] drive_data, sample_data, pad_direct, last_word;
  int         errors, samples_checked, cycles, pops, p0;

  gpiode_top dut (
    .mclk(mclk), .rst_b(rst_b), .pad_in(pad_wire), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .launch_clock(launch_clock), .capture_clock(capture_clock),
    .configuring(configuring), .pad_mode(pad_mode),
    .dual_edge_io(dual_edge_io), .in_reg_en(in_reg_en),
    .in_edge_fall(fall0), .out_reg_en(out_reg_en), .out_invert(out_invert),
    .out_edge_fall(fall0), .oe_reg_en(oe_reg_en), .oe_edge_fall(fall0),
    .drive_data(drive_data), .drive_en(drive_en),
    .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .pad_direct(pad_direct),
    .secondary_dest(secondary_dest),
    .secondary_pad_route(secondary_pad_route), .overrun(overrun),
    .overrun_clear(overrun_clear)
  );

  gpiode_pad_model board (
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .ext_en(ext_en), .ext_val(ext_val), .pad_wire(pad_wire)
  );

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  always @(posedge mclk)
  begin
    if (sample_valid === 1'b1 && sample_ready === 1'b1)
    begin
      last_word <= sample_data;
      pops <= pops + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [4:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic setup(input logic [4:0] m, input logic [2:0] d,
                       input logic [3:0] regs);
    @(posedge mclk);
    pad_mode <= m;
    dual_edge_io <= d;
    {in_reg_en, out_reg_en, out_invert, oe_reg_en} <= regs;
    cyc(8);
  endtask : setup

  task automatic lch(input logic v);
    @(posedge mclk);
    launch_clock <= v;
    cyc(10);
    @(negedge mclk);
  endtask : lch

  task automatic cap(input logic v, pv);
    @(posedge mclk);
    ext_val <= pv;
    cyc(5);
    capture_clock <= v;
    cyc(10);
  endtask : cap

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    {errors, samples_checked, cycles, pops} = '0;
    {rst_b, launch_clock, capture_clock, configuring, drive_en} = '0;
    {in_reg_en, out_reg_en, out_invert, oe_reg_en, fall0} = '0;
    {sample_ready, overrun_clear, ext_en, ext_val, drive_data} = '0;
    pad_mode = gpiode_pkg::GPIODE_MODE_UNUSED;
    dual_edge_io = gpiode_pkg::GPIODE_DE_NONE;
    secondary_dest = 5'h04;
    last_word = 2'h0;
    cyc(4);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk("oe", 5'h00, pad_oe);
    chk("pull_up", 5'h01, pad_pull_up);
    $display("test reset done");
    setup(gpiode_pkg::GPIODE_MODE_BIDIR, gpiode_pkg::GPIODE_DE_NONE, 4'h0);
    drive_en <= 1'b1;
    drive_data <= 2'h1;
    lch(1'b0);
    chk("pad", 5'h01, pad_wire);
    chk("direct", 5'h01, pad_direct[0]);
    cyc(1);
    drive_en <= 1'b0;
    ext_en <= 1'b1;
    lch(1'b0);
    chk("oe", 5'h00, pad_oe);
    chk("direct", 5'h00, pad_direct[0]);
    cyc(1);
    configuring <= 1'b1;
    lch(1'b0);
    chk("cfg pull_up", 5'h01, pad_pull_up & ~pad_oe);
    cyc(1);
    configuring <= 1'b0;
    $display("test bidir done");
    setup(gpiode_pkg::GPIODE_MODE_INPUT, gpiode_pkg::GPIODE_DE_NONE, 4'h0);
    ext_val <= 1'b1;
    lch(1'b0);
    chk("route", 5'h04, secondary_pad_route);
    cyc(1);
    in_reg_en <= 1'b1;
    lch(1'b0);
    chk("route", 5'h00, secondary_pad_route);
    $display("test route done");
    setup(gpiode_pkg::GPIODE_MODE_OUTPUT, gpiode_pkg::GPIODE_DE_NONE, 4'h6);
    ext_en <= 1'b0;
    drive_data <= 2'h1;
    lch(1'b1);
    chk("inverted", 5'h00, pad_out);
    cyc(1);
    drive_data <= 2'h0;
    lch(1'b0);
    chk("held", 5'h00, pad_out);
    lch(1'b1);
    chk("inverted", 5'h01, pad_out);
    cyc(1);
    fall0 <= 1'b1;
    drive_data <= 2'h1;
    lch(1'b0);
    chk("fall edge", 5'h00, pad_out);
    cyc(1);
    drive_data <= 2'h0;
    lch(1'b1);
    chk("rise held", 5'h00, pad_out);
    $display("test out reg done");
    setup(gpiode_pkg::GPIODE_MODE_CLKOUT, gpiode_pkg::GPIODE_DE_NONE, 4'h0);
    fall0 <= 1'b0;
    lch(1'b0);
    chk("clkout low", 5'h00, pad_out);
    lch(1'b1);
    chk("clkout high", 5'h01, pad_out & pad_oe);
    setup(gpiode_pkg::GPIODE_MODE_OUTPUT, gpiode_pkg::GPIODE_DE_NONE, 4'h0);
    drive_data <= 2'h1;
    lch(1'b1);
    chk("direct out", 5'h01, pad_out);
    $display("test clock out done");
    for (int i = 0; i < 2; i++)
    begin
      de = i ? gpiode_pkg::GPIODE_DE_RESYNC : gpiode_pkg::GPIODE_DE_NORMAL;
      setup(gpiode_pkg::GPIODE_MODE_OUTPUT, de, 4'h4);
      ext_en <= 1'b0;
      drive_data <= 2'h2;
      lch(1'b0);
      lch(1'b1);
      chk("rise out", 5'h00, pad_out);
      lch(1'b0);
      chk("fall out", 5'h01, pad_out);
      setup(gpiode_pkg::GPIODE_MODE_INPUT, de, 4'h8);
      ext_en <= 1'b1;
      sample_ready <= 1'b1;
      repeat (4)
      begin
        cap(1'b1, 1'b1);
        cap(1'b0, 1'b0);
      end
      cyc(10);
      chk("word", 5'h01, last_word);
    end
    $display("test dual edge done");
    setup(gpiode_pkg::GPIODE_MODE_INPUT, gpiode_pkg::GPIODE_DE_NONE, 4'h8);
    sample_ready <= 1'b0;
    repeat (20)
    begin
      cap(1'b1, 1'b1);
      cap(1'b0, 1'b1);
    end
    chk("overrun", 5'h01, overrun);
    p0 = pops;
    sample_ready <= 1'b1;
    cyc(60);
    chk("drained", 5'h11, 5'(pops - p0));
    chk("bit0", 5'h01, last_word[0]);
    overrun_clear <= 1'b1;
    cyc(1);
    overrun_clear <= 1'b0;
    lch(1'b0);
    chk("overrun", 5'h00, overrun);
    $display("test buffer done");
    wrap_up();
  end
endmodule : gpiode_top_tb

`default_nettype wire
